// ---- hdl/sbp_regs.svh ----
// register offsets, field positions, reset values for the six-bit port
`ifndef SBP_REGS_SVH
`define SBP_REGS_SVH

// ----------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------
`define SBP_OFS_PIN_LEVEL   5'h00
`define SBP_OFS_OUT_LATCH   5'h04
`define SBP_OFS_DIRECTION   5'h08
`define SBP_OFS_ANALOG_SEL  5'h0c
`define SBP_OFS_OPEN_DRAIN  5'h10
`define SBP_OFS_SLEW_LIMIT  5'h14
`define SBP_OFS_PULL_UP     5'h18
`define SBP_OFS_PERIPH_EN   5'h1c

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define SBP_PIN_COUNT       6
`define SBP_INPUT_ONLY_POS  3
`define SBP_INPUT_ONLY_MASK 6'h08
`define SBP_ANALOG_IMPL     6'h17
`define SBP_RST_DIRECTION   6'h3f
`define SBP_RST_ANALOG_SEL  6'h17
`define SBP_RST_OUT_LATCH   6'h00
`define SBP_RST_OPEN_DRAIN  6'h00
`define SBP_RST_SLEW_LIMIT  6'h3f
`define SBP_RST_PULL_UP     6'h3f
`define SBP_RST_PERIPH_EN   6'h00

`endif

// ---- hdl/sbp_pkg.sv ----
// types shared by the six-bit port design
package sbp_pkg;

    // ----------------------------------------------------------------
    // one bit per pin position
    // ----------------------------------------------------------------
    typedef logic [5:0] sbp_pins_t;

    // ----------------------------------------------------------------
    // register selected by the bus address
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SBP_REG_PIN_LEVEL,
        SBP_REG_OUT_LATCH,
        SBP_REG_DIRECTION,
        SBP_REG_ANALOG_SEL,
        SBP_REG_OPEN_DRAIN,
        SBP_REG_SLEW_LIMIT,
        SBP_REG_PULL_UP,
        SBP_REG_PERIPH_EN
    } sbp_reg_sel_t;

endpackage

// ---- hdl/sbp_port.sv ----
// six-bit bidirectional general-purpose port with avalon-mm register access
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "sbp_regs.svh"

// What this block does
// - six pins, each with direction, latch, level bits
// - direction one makes pin input, driver off
// - direction zero drives latch value onto pin
// - pin three input only, direction reads one
// - level read shows pins, write goes latch
// - level writes are read-modify-write into latch
// - latch write acts like level write
// - latch read returns stored latch bits
// - analog select disables digital input buffer
// - analog pins read zero through level register
// - direction still gates driver in analog mode
// - open drain drives low only
// - open drain clear means push-pull drive
// - peripheral owns output, level stays readable
// - analog select bits set after reset
// - pull-up off whenever pin is output
// - slew limit bit limits pin edge rate
module sbp_port (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [3:0]  avs_byteenable_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // pin pads, three signals per pin
    input  wire logic [5:0]  pin_in_i,
    output logic      [5:0]  pin_out_o,
    output logic      [5:0]  pin_oe_o,
    // pad controls
    output logic      [5:0]  pin_in_buf_en_o,
    output logic      [5:0]  pin_pull_up_o,
    output logic      [5:0]  pin_slew_limit_o,
    // on-chip peripherals taking over pins
    input  wire logic [5:0]  periph_out_i,
    input  wire logic [5:0]  periph_oe_i,
    output logic      [5:0]  pin_level_o
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------

    // map a byte address onto a register, valid flag beside it
    // misaligned addresses are unmapped: reads give zero, writes drop
    function automatic logic decode_hit(input logic [4:0] addr);
        decode_hit = (addr[1:0] == 2'h0);
    endfunction

    // register selector from the word part of the address
    function automatic sbp_pkg::sbp_reg_sel_t decode_sel(input logic [4:0] addr);
        decode_sel = sbp_pkg::sbp_reg_sel_t'(addr[4:2]);
    endfunction

    // merge a write into pin values: lane zero replaces, else pins kept
    function automatic sbp_pkg::sbp_pins_t rmw_merge(
        input sbp_pkg::sbp_pins_t pins,
        input logic [3:0]         be,
        input logic [31:0]        wdata
    );
        rmw_merge = be[0] ? wdata[5:0] : pins;
    endfunction

    // byte-lane write into a plain control register
    function automatic sbp_pkg::sbp_pins_t lane_write(
        input sbp_pkg::sbp_pins_t old,
        input logic [3:0]         be,
        input logic [31:0]        wdata
    );
        lane_write = be[0] ? wdata[5:0] : old;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    sbp_pkg::sbp_pins_t direction;
    sbp_pkg::sbp_pins_t out_latch;
    sbp_pkg::sbp_pins_t analog_sel;
    sbp_pkg::sbp_pins_t open_drain;
    sbp_pkg::sbp_pins_t slew_limit;
    sbp_pkg::sbp_pins_t pull_up;
    sbp_pkg::sbp_pins_t periph_en;
    sbp_pkg::sbp_pins_t sync_meta;
    sbp_pkg::sbp_pins_t sync_level;

    // ----------------------------------------------------------------
    // combinational values
    // ----------------------------------------------------------------
    logic                 bus_req;
    logic                 bus_take;
    logic                 wr_take;
    logic                 addr_ok;
    sbp_pkg::sbp_reg_sel_t reg_sel;
    sbp_pkg::sbp_pins_t   dir_eff;
    sbp_pkg::sbp_pins_t   level_read;
    sbp_pkg::sbp_pins_t   drive_val;
    sbp_pkg::sbp_pins_t   drive_en;
    sbp_pkg::sbp_pins_t   next_pin_out;
    sbp_pkg::sbp_pins_t   next_pin_oe;
    logic [31:0]          next_readdata;

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------

    // a request is taken at the edge where waitrequest is seen low
    assign bus_req  = avs_read_i | avs_write_i;
    assign bus_take = bus_req & ~avs_waitrequest_o;
    assign wr_take  = avs_write_i & bus_take & addr_ok;
    assign addr_ok  = decode_hit(avs_address_i);
    assign reg_sel  = decode_sel(avs_address_i);

    // waitrequest is registered, so each access costs two cycles
    // one wait cycle for every request, then ready for exactly one edge
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
        end
    end

    // ----------------------------------------------------------------
    // pin level synchroniser
    // ----------------------------------------------------------------

    // two flops before anything looks at the pad levels
    // only the second stage feeds logic, the first may be metastable
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sync_meta  <= 6'h00;
            sync_level <= 6'h00;
        end else begin
            sync_meta  <= pin_in_i;
            sync_level <= sync_meta;
        end
    end

    // analog pins have the digital buffer off and read as zero
    assign level_read = sync_level & ~analog_sel;

    // ----------------------------------------------------------------
    // direction register
    // ----------------------------------------------------------------

    // input-only position is forced to one whatever is written
    // dir_eff masks it again so no write path can drive that pad
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            direction <= `SBP_RST_DIRECTION;
        end else if (wr_take && reg_sel == sbp_pkg::SBP_REG_DIRECTION) begin
            direction <= lane_write(direction, avs_byteenable_i, avs_writedata_i)
                         | `SBP_INPUT_ONLY_MASK;
        end
    end

    // ----------------------------------------------------------------
    // output latch
    // ----------------------------------------------------------------

    // level and latch writes share one read-modify-write path
    // with lane zero off the latch reloads from the pins as they read now
    // hazard: an analog pin reads zero, so such a write clears its latch bit
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            out_latch <= `SBP_RST_OUT_LATCH;
        end else if (wr_take && (reg_sel == sbp_pkg::SBP_REG_PIN_LEVEL ||
                                 reg_sel == sbp_pkg::SBP_REG_OUT_LATCH)) begin
            out_latch <= rmw_merge(level_read, avs_byteenable_i, avs_writedata_i);
        end
    end

    // ----------------------------------------------------------------
    // analog select
    // ----------------------------------------------------------------

    // only the implemented positions hold a bit, all set after reset
    // unimplemented positions stay zero whatever is written
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            analog_sel <= `SBP_RST_ANALOG_SEL;
        end else if (wr_take && reg_sel == sbp_pkg::SBP_REG_ANALOG_SEL) begin
            analog_sel <= lane_write(analog_sel, avs_byteenable_i, avs_writedata_i)
                          & `SBP_ANALOG_IMPL;
        end
    end

    // ----------------------------------------------------------------
    // open drain select
    // ----------------------------------------------------------------

    // independent per pin
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            open_drain <= `SBP_RST_OPEN_DRAIN;
        end else if (wr_take && reg_sel == sbp_pkg::SBP_REG_OPEN_DRAIN) begin
            open_drain <= lane_write(open_drain, avs_byteenable_i, avs_writedata_i);
        end
    end

    // ----------------------------------------------------------------
    // slew limit select
    // ----------------------------------------------------------------

    // passed to the pad as a level
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            slew_limit <= `SBP_RST_SLEW_LIMIT;
        end else if (wr_take && reg_sel == sbp_pkg::SBP_REG_SLEW_LIMIT) begin
            slew_limit <= lane_write(slew_limit, avs_byteenable_i, avs_writedata_i);
        end
    end

    // ----------------------------------------------------------------
    // pull-up enable
    // ----------------------------------------------------------------

    // enable bits only; output pins mask them at the pad
    // a pull-up left on under a driven pad would waste current
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pull_up <= `SBP_RST_PULL_UP;
        end else if (wr_take && reg_sel == sbp_pkg::SBP_REG_PULL_UP) begin
            pull_up <= lane_write(pull_up, avs_byteenable_i, avs_writedata_i);
        end
    end

    // ----------------------------------------------------------------
    // peripheral ownership
    // ----------------------------------------------------------------

    // a set bit hands the pin output to the on-chip peripheral
    // the level read path is untouched, so an owned pin stays readable
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            periph_en <= `SBP_RST_PERIPH_EN;
        end else if (wr_take && reg_sel == sbp_pkg::SBP_REG_PERIPH_EN) begin
            periph_en <= lane_write(periph_en, avs_byteenable_i, avs_writedata_i);
        end
    end

    // ----------------------------------------------------------------
    // output driver logic
    // ----------------------------------------------------------------

    // the input-only position never gets a driver
    assign dir_eff = direction | `SBP_INPUT_ONLY_MASK;

    // pick source and enable per pin, then apply open drain
    // a peripheral cannot drive a pin whose direction bit says input
    // open drain releases the pad for a one; the far side pulls it high
    always_comb begin
        drive_val    = 6'h00;
        drive_en     = 6'h00;
        next_pin_out = 6'h00;
        next_pin_oe  = 6'h00;
        for (int i = 0; i < `SBP_PIN_COUNT; i++) begin
            if (periph_en[i]) begin
                drive_val[i] = periph_out_i[i];
                drive_en[i]  = periph_oe_i[i] & ~dir_eff[i];
            end else begin
                drive_val[i] = out_latch[i];
                drive_en[i]  = ~dir_eff[i];
            end
            if (open_drain[i]) begin
                next_pin_out[i] = 1'b0;
                next_pin_oe[i]  = drive_en[i] & ~drive_val[i];
            end else begin
                next_pin_out[i] = drive_val[i];
                next_pin_oe[i]  = drive_en[i];
            end
        end
    end

    // pad outputs come straight from flops
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pin_out_o <= 6'h00;
            pin_oe_o  <= 6'h00;
        end else begin
            pin_out_o <= next_pin_out;
            pin_oe_o  <= next_pin_oe;
        end
    end

    // ----------------------------------------------------------------
    // pad controls
    // ----------------------------------------------------------------

    // buffer, pull-up, slew and level outputs, all registered
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pin_in_buf_en_o  <= 6'h00;
            pin_pull_up_o    <= 6'h00;
            pin_slew_limit_o <= 6'h00;
            pin_level_o      <= 6'h00;
        end else begin
            pin_in_buf_en_o  <= ~analog_sel;
            pin_pull_up_o    <= pull_up & dir_eff;
            pin_slew_limit_o <= slew_limit;
            pin_level_o      <= level_read;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------

    // select the addressed register, unmapped reads as zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (addr_ok) begin
            unique case (reg_sel)
                sbp_pkg::SBP_REG_PIN_LEVEL:  next_readdata[5:0] = level_read;
                sbp_pkg::SBP_REG_OUT_LATCH:  next_readdata[5:0] = out_latch;
                sbp_pkg::SBP_REG_DIRECTION:  next_readdata[5:0] = dir_eff;
                sbp_pkg::SBP_REG_ANALOG_SEL: next_readdata[5:0] = analog_sel;
                sbp_pkg::SBP_REG_OPEN_DRAIN: next_readdata[5:0] = open_drain;
                sbp_pkg::SBP_REG_SLEW_LIMIT: next_readdata[5:0] = slew_limit;
                sbp_pkg::SBP_REG_PULL_UP:    next_readdata[5:0] = pull_up;
                sbp_pkg::SBP_REG_PERIPH_EN:  next_readdata[5:0] = periph_en;
            endcase
        end
    end

    // capture during the wait cycle so data stands when waitrequest drops
    // readdata then holds until the next read reloads it
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= next_readdata;
        end
    end

endmodule

// ---- testbench/sbp_port_assertions.sv ----
// concurrent checks on the six-bit port bus and pad outputs
`timescale 1ns/100ps
module sbp_port_assertions (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [5:0]  pin_in_i,
    input wire logic [5:0]  pin_oe_o,
    input wire logic [5:0]  pin_in_buf_en_o,
    input wire logic [5:0]  pin_pull_up_o,
    input wire logic [5:0]  pin_level_o
);
    // ----------------------------------------------------------------
    // bus handshake and pad relations
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic req;
    assign req = avs_read_i | avs_write_i;
    a_wait_answer: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered after one cycle");
    a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait_high: assert property (!req && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer without request");
    a_read_upper_zero: assert property (avs_readdata_o[31:6] == 26'h0)
        else $error("read data above bit five not zero");
    a_input_only_pin: assert property (pin_oe_o[3] == 1'b0)
        else $error("input only pin driven");
    a_pull_off_out: assert property ((pin_pull_up_o & pin_oe_o) == 6'h00)
        else $error("pull-up active on driven pin");
    a_analog_reads_zero: assert property ((~pin_in_buf_en_o & pin_level_o) == 6'h00)
        else $error("analog pin level not zero");
    a_level_follows_pin: assert property (($stable(pin_in_i) && $stable(pin_in_buf_en_o))[*5]
        |-> pin_level_o == (pin_in_i & pin_in_buf_en_o))
        else $error("pin level does not follow settled pad");
    c_write_taken: cover property (avs_write_i && !avs_waitrequest_o);
    c_read_taken: cover property (avs_read_i && !avs_waitrequest_o);
    c_pin_driven: cover property (pin_oe_o != 6'h00);
endmodule
bind sbp_port sbp_port_assertions u_chk (
    .clk_i             (clk_i),
    .reset_n_i         (reset_n_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .pin_in_i          (pin_in_i),
    .pin_oe_o          (pin_oe_o),
    .pin_in_buf_en_o   (pin_in_buf_en_o),
    .pin_pull_up_o     (pin_pull_up_o),
    .pin_level_o       (pin_level_o)
);

// ---- testbench/sbp_pins_model.sv ----
// external pads: device driver, far-side driver, pull-up, floating
`timescale 1ns/100ps
module sbp_pins_model (
    // clock for the floating pattern
    input  wire logic       clk_i,
    // device pad side
    input  wire logic [5:0] pin_out_i,
    input  wire logic [5:0] pin_oe_i,
    input  wire logic [5:0] pin_pull_up_i,
    // far-side drivers
    input  wire logic [5:0] ext_oe_i,
    input  wire logic [5:0] ext_val_i,
    output logic      [5:0] pin_in_o
);
    // ----------------------------------------------------------------
    // wire level resolution
    // ----------------------------------------------------------------
    logic [5:0] toggle = 6'h15;
    // undriven lines change every cycle
    always @(posedge clk_i) toggle <= ~toggle;
    // device driver first, then far side, then weak pull-up
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pin_oe_i[i]) pin_in_o[i] = pin_out_i[i];
            else if (ext_oe_i[i]) pin_in_o[i] = ext_val_i[i];
            else if (pin_pull_up_i[i]) pin_in_o[i] = 1'b1;
            else pin_in_o[i] = toggle[i];
        end
    end
endmodule

// ---- testbench/sbp_port_tb_top.sv ----
// register-level testbench for the six-bit port
`timescale 1ns/100ps
module sbp_port_tb_top;
    // ----------------------------------------------------------------
    // signals, instances, clock
    // ----------------------------------------------------------------
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [4:0]  avs_address_i = 5'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [3:0]  avs_byteenable_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [5:0]  pin_in_i, pin_out_o, pin_oe_o, pin_in_buf_en_o, pin_pull_up_o, pin_slew_limit_o, pin_level_o;
    logic [5:0]  periph_out_i = 6'h00;
    logic [5:0]  periph_oe_i = 6'h00;
    logic [5:0]  ext_oe = 6'h00;
    logic [5:0]  ext_val = 6'h00;
    logic [5:0]  rst_val [8] = '{6'h28, 6'h00, 6'h3f, 6'h17, 6'h00, 6'h3f, 6'h3f, 6'h00};
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    sbp_port dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .pin_in_i(pin_in_i),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_in_buf_en_o(pin_in_buf_en_o), .pin_pull_up_o(pin_pull_up_o),
        .pin_slew_limit_o(pin_slew_limit_o), .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i),
        .pin_level_o(pin_level_o));
    sbp_pins_model pads (.clk_i(clk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pin_pull_up_i(pin_pull_up_o),
        .ext_oe_i(ext_oe), .ext_val_i(ext_val), .pin_in_o(pin_in_i));
    initial forever #10 clk_i = ~clk_i;
    // cut a hang short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [5:0] d);
        logic [31:0] q;
        bus(1'b1, a, {26'h0, d}, 4'h1, q);
    endtask
    task automatic rdc(input string nm, input logic [4:0] a, input logic [5:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'h0, q);
        chk(nm, q, {26'h0, e});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] q;
        settle(4);
        reset_n_i <= 1'b1;
        settle(3);
        chk("oe", pin_oe_o, 6'h00);
        chk("buf", pin_in_buf_en_o, 6'h28);
        chk("pull", pin_pull_up_o, 6'h3f);
        chk("slew", pin_slew_limit_o, 6'h3f);
        for (int i = 0; i < 8; i++) rdc("reset", 5'(i * 4), rst_val[i]);
        rdc("unmapped", 5'h01, 6'h00);
        // digital buffers on, pull-ups give ones
        wr(5'h0c, 6'h00);
        settle(4);
        rdc("level", 5'h00, 6'h3f);
        // drive latch, pin three stays input
        wr(5'h08, 6'h00);
        rdc("dir", 5'h08, 6'h08);
        wr(5'h04, 6'h15);
        settle(2);
        chk("oe", pin_oe_o, 6'h37);
        chk("out", pin_out_o & pin_oe_o, 6'h15);
        chk("pull", pin_pull_up_o, 6'h08);
        rdc("latch", 5'h04, 6'h15);
        settle(4);
        rdc("level", 5'h00, 6'h1d);
        chk("level_o", pin_level_o, 6'h1d);
        wr(5'h00, 6'h2a);
        wr(5'h05, 6'h3f);
        rdc("latch", 5'h04, 6'h2a);
        // open drain sinks only
        wr(5'h10, 6'h3f);
        settle(2);
        chk("od_oe", pin_oe_o, 6'h15);
        chk("od_out", pin_out_o, 6'h00);
        wr(5'h10, 6'h00);
        settle(2);
        chk("pp_out", pin_out_o & pin_oe_o, 6'h22);
        // write with no lane loads latch from pins
        wr(5'h08, 6'h3f);
        ext_oe <= 6'h3f;
        ext_val <= 6'h33;
        settle(4);
        bus(1'b1, 5'h00, 32'h0, 4'h0, q);
        rdc("rmw", 5'h04, 6'h33);
        ext_oe <= 6'h00;
        // peripheral takes pin zero
        wr(5'h08, 6'h00);
        periph_oe_i <= 6'h01;
        wr(5'h1c, 6'h01);
        settle(2);
        chk("periph", pin_out_o & pin_oe_o, 6'h32);
        settle(4);
        rdc("plevel", 5'h00, 6'h3a);
        chk("plevel_o", pin_level_o, 6'h3a);
        // analog pins keep their driver, read zero
        wr(5'h1c, 6'h00);
        wr(5'h0c, 6'h11);
        settle(2);
        chk("an_oe", pin_oe_o, 6'h37);
        chk("an_buf", pin_in_buf_en_o, 6'h2e);
        settle(4);
        rdc("an_level", 5'h00, 6'h2a);
        chk("an_level_o", pin_level_o, 6'h2a);
        wr(5'h14, 6'h0c);
        settle(2);
        chk("slew", pin_slew_limit_o, 6'h0c);
        conclude();
    end
endmodule
